// ==== design/lct_level_timing.sv ====
// Overview of operation
// - Release rate field, bits 7:4, reset 0011.
// - Attack rate field, bits 3:0, reset 0010.
// - Normal release: 0.41ms doubling to 840ms.
// - Limiter release: 0.082ms doubling to 168ms.
// - Normal attack: 0.104ms doubling to 106ms.
// - Limiter attack: 0.020ms doubling to 20.5ms.
// - Above 48kHz always use normal-style times.
// - Peak over limit forces fastest attack rate.
// - Limiter acts only in active operation.
// - Released ramp steps once per release interval.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Step timing for the record-path automatic level control.
module lct_level_timing
  import lct_pkg::*;
#(
  parameter int CNT_W = 20
) (
  // Clock, reset and clock enable.
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // Register port.
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  // Level information from the detector, same clock domain.
  input  wire logic        sampleTick,
  input  wire logic        levelAboveTarget,
  input  wire logic        holdExpired,
  input  wire logic        peakOverLimit,
  // Gain step requests and state.
  output logic             gainDownStep,
  output logic             gainUpStep,
  output logic             limiterActive
);

  // Scaled arithmetic needs at least 18 bits of count.
  if (CNT_W < 18) begin : gChk
    $error("lct_level_timing: CNT_W must be at least 18.");
  end

  // Weight of one sample period in 96 kHz units for a rate code.
  function automatic logic [3:0] rateWeight(input logic [3:0] sel);
    case (sel)
      LCT_RATE_8K:  rateWeight = 4'hC;
      LCT_RATE_11K: rateWeight = 4'h8;
      LCT_RATE_12K: rateWeight = 4'h8;
      LCT_RATE_16K: rateWeight = 4'h6;
      LCT_RATE_22K: rateWeight = 4'h4;
      LCT_RATE_24K: rateWeight = 4'h4;
      LCT_RATE_32K: rateWeight = 4'h3;
      LCT_RATE_44K: rateWeight = 4'h2;
      LCT_RATE_88K: rateWeight = 4'h1;
      LCT_RATE_96K: rateWeight = 4'h1;
      default:      rateWeight = 4'h2;
    endcase
  endfunction : rateWeight

  // Interval limit: the code-zero time doubled once per code step.
  function automatic logic [CNT_W-1:0] stepLimit(
    input logic [7:0] base,
    input logic [3:0] code,
    input logic [3:0] maxCode
  );
    logic [3:0] useCode;
    useCode = (code > maxCode) ? maxCode : code;
    stepLimit = {{(CNT_W-8){1'b0}}, base} << useCode;
  endfunction : stepLimit

  lct_timing_t timing_r;       // Timing register.
  lct_cfg_t    cfg_r;          // Configuration register.
  logic [15:0] rdData_r;       // Read data, valid one cycle.
  logic        gainDown_r;     // Attenuation step request.
  logic        gainUp_r;       // Gain increase step request.
  logic        limiter_r;      // Limiter forcing fastest attack.

  logic        wrTiming;       // Write strobe hits timing register.
  logic        wrCfg;          // Write strobe hits configuration register.
  logic        ctrlOn;         // At least one channel under control.
  logic        highRate;       // 88.2 kHz or 96 kHz selected.
  logic        limStyle;       // Effective limiter style.
  logic        limForce;       // Limiter overrides attack code.
  logic [3:0]  atkCode;        // Attack code in use.
  logic [7:0]  relBase;        // Code-zero release time in units.
  logic [7:0]  atkBase;        // Code-zero attack time in units.
  logic [CNT_W-1:0] relLimit;  // Release interval in units.
  logic [CNT_W-1:0] atkLimit;  // Attack interval in units.
  logic [3:0]  weight;         // Units per sample period.
  logic        downRun;        // Attenuation ramp in progress.
  logic        upRun;          // Gain increase ramp in progress.
  logic        downDue;        // Attack interval has ended.
  logic        upDue;          // Release interval has ended.
  logic [15:0] timingView;     // Timing register as read back.
  logic [15:0] cfgView;        // Configuration register as read back.
  logic [15:0] statusView;     // Status register as read back.
  logic [15:0] rdMux;          // Selected read value.

  // Address decode of the write strobe.
  assign wrTiming = regWrEn && (regAddr == LCT_OFS_TIMING);
  assign wrCfg    = regWrEn && (regAddr == LCT_OFS_CFG);

  // Style selection falls back to normal at the high rates.
  assign ctrlOn   = cfg_r.left || cfg_r.right;
  assign highRate = (cfg_r.rateSel == LCT_RATE_88K) ||
                    (cfg_r.rateSel == LCT_RATE_96K);
  assign limStyle = timing_r.style && !highRate;

  // The peak limiter only acts while control is active.
  assign limForce = peakOverLimit && ctrlOn && cfg_r.active;
  // An overload selects the code-zero attack time.
  assign atkCode  = limForce ? 4'h0 : timing_r.attack;

  // Base times for the style in use.
  assign relBase = limStyle ? LCT_LIM_REL_U : LCT_NORM_REL_U;
  assign atkBase = limStyle ? LCT_LIM_ATK_U : LCT_NORM_ATK_U;

  // Interval lengths; reserved codes behave as the longest code.
  assign relLimit = stepLimit(relBase, timing_r.gainReleaseRate, LCT_REL_MAX);
  assign atkLimit = stepLimit(atkBase, atkCode, LCT_ATK_MAX);
  assign weight   = rateWeight(cfg_r.rateSel);

  // Attenuation runs on a high level or an overload.
  assign downRun = ctrlOn && (levelAboveTarget || limForce);
  // Increase runs once the hold delay has expired.
  assign upRun   = ctrlOn && holdExpired;

  // Attack interval timer.
  lct_step_timer #(
    .CNT_W      (CNT_W)
  ) uAtkTimer (
    .core_clk   (core_clk),
    .srst       (srst),
    .clkEn      (clkEn),
    .run        (downRun),
    .clear      (1'b0),
    .sampleTick (sampleTick),
    .weight     (weight),
    .limit      (atkLimit),
    .due        (downDue)
  );

  // Release interval timer; restarts when an attenuation step wins.
  lct_step_timer #(
    .CNT_W      (CNT_W)
  ) uRelTimer (
    .core_clk   (core_clk),
    .srst       (srst),
    .clkEn      (clkEn),
    .run        (upRun),
    .clear      (downDue),
    .sampleTick (sampleTick),
    .weight     (weight),
    .limit      (relLimit),
    .due        (upDue)
  );

  // Read-back views; unused bits read as zero.
  assign timingView = {7'h00, timing_r.style, timing_r.gainReleaseRate,
                       timing_r.attack};
  assign cfgView    = {8'h00, cfg_r.rateSel, 1'b0, cfg_r.active,
                       cfg_r.right, cfg_r.left};
  assign statusView = {12'h000, highRate, limStyle, upRun, limiter_r};

  // Read selection; unmapped addresses return zero.
  assign rdMux = (regAddr == LCT_OFS_TIMING) ? timingView :
                 (regAddr == LCT_OFS_CFG)    ? cfgView    :
                 (regAddr == LCT_OFS_STATUS) ? statusView : 16'h0000;

  // Timing register with its documented reset codes.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timing_r.style           <= LCT_STYLE_RST;
      timing_r.gainReleaseRate <= LCT_REL_RST;
      timing_r.attack          <= LCT_ATK_RST;
    end else if (clkEn && wrTiming) begin
      timing_r.style           <= regWrData[LCT_STYLE_BIT];
      timing_r.gainReleaseRate <= regWrData[LCT_REL_LSB +: 4];
      timing_r.attack          <= regWrData[LCT_ATK_LSB +: 4];
    end
  end

  // Configuration register: enables, active mode and sample rate.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_r.left    <= 1'b0;
      cfg_r.right   <= 1'b0;
      cfg_r.active  <= 1'b0;
      cfg_r.rateSel <= LCT_RATE_RST;
    end else if (clkEn && wrCfg) begin
      cfg_r.left    <= regWrData[LCT_LEFT_BIT];
      cfg_r.right   <= regWrData[LCT_RIGHT_BIT];
      cfg_r.active  <= regWrData[LCT_ACTIVE_BIT];
      cfg_r.rateSel <= regWrData[LCT_RATE_LSB +: 4];
    end
  end

  // Read data stands for the one cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_r <= 16'h0000;
    end else if (clkEn) begin
      rdData_r <= regRdEn ? rdMux : 16'h0000;
    end
  end

  // Step requests are single-cycle pulses; attenuation has priority.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gainDown_r <= 1'b0;
      gainUp_r   <= 1'b0;
      limiter_r  <= 1'b0;
    end else if (clkEn) begin
      gainDown_r <= downDue;
      gainUp_r   <= upDue && !downDue;
      limiter_r  <= limForce;
    end
  end

  // Outputs straight from flip-flops.
  assign regRdData     = rdData_r;
  assign gainDownStep  = gainDown_r;
  assign gainUpStep    = gainUp_r;
  assign limiterActive = limiter_r;

endmodule : lct_level_timing

`default_nettype wire

// ==== design/lct_pkg.sv ====
package lct_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] LCT_OFS_TIMING = 8'h13;
  localparam logic [7:0] LCT_OFS_CFG    = 8'h30;
  localparam logic [7:0] LCT_OFS_STATUS = 8'h31;

  // Field positions inside the timing register.
  localparam int LCT_ATK_LSB   = 0;
  localparam int LCT_REL_LSB   = 4;
  localparam int LCT_STYLE_BIT = 8;

  // Field positions inside the configuration register.
  localparam int LCT_LEFT_BIT   = 0;
  localparam int LCT_RIGHT_BIT  = 1;
  localparam int LCT_ACTIVE_BIT = 2;
  localparam int LCT_RATE_LSB   = 4;

  // Reset values of the fields.
  localparam logic [3:0] LCT_REL_RST   = 4'h3;
  localparam logic [3:0] LCT_ATK_RST   = 4'h2;
  localparam logic       LCT_STYLE_RST = 1'b0;
  localparam logic [3:0] LCT_RATE_RST  = 4'h8;

  // Highest codes that carry a defined step time.
  localparam logic [3:0] LCT_REL_MAX = 4'hB;
  localparam logic [3:0] LCT_ATK_MAX = 4'hA;

  // Sample rate selector codes.
  localparam logic [3:0] LCT_RATE_8K   = 4'h0;
  localparam logic [3:0] LCT_RATE_11K  = 4'h1;
  localparam logic [3:0] LCT_RATE_12K  = 4'h2;
  localparam logic [3:0] LCT_RATE_16K  = 4'h3;
  localparam logic [3:0] LCT_RATE_22K  = 4'h4;
  localparam logic [3:0] LCT_RATE_24K  = 4'h5;
  localparam logic [3:0] LCT_RATE_32K  = 4'h6;
  localparam logic [3:0] LCT_RATE_44K  = 4'h7;
  localparam logic [3:0] LCT_RATE_48K  = 4'h8;
  localparam logic [3:0] LCT_RATE_88K  = 4'h9;
  localparam logic [3:0] LCT_RATE_96K  = 4'hA;

  // Step time of code zero for each style, in microseconds.
  localparam int LCT_NORM_REL_US = 410;
  localparam int LCT_NORM_ATK_US = 104;
  localparam int LCT_LIM_REL_US  = 82;
  localparam int LCT_LIM_ATK_US  = 20;

  // Timing is counted in units of one 96 kHz sample period.
  localparam int LCT_UNIT_KHZ = 96;

  // Code-zero step times in 96 kHz units, rounded to nearest.
  localparam logic [7:0] LCT_NORM_REL_U =
    8'((LCT_NORM_REL_US * LCT_UNIT_KHZ + 500) / 1000);
  localparam logic [7:0] LCT_NORM_ATK_U =
    8'((LCT_NORM_ATK_US * LCT_UNIT_KHZ + 500) / 1000);
  localparam logic [7:0] LCT_LIM_REL_U  =
    8'((LCT_LIM_REL_US * LCT_UNIT_KHZ + 500) / 1000);
  localparam logic [7:0] LCT_LIM_ATK_U  =
    8'((LCT_LIM_ATK_US * LCT_UNIT_KHZ + 500) / 1000);

  // Timing register contents.
  typedef struct packed {
    logic       style;            // Set selects limiter style.
    logic [3:0] gainReleaseRate;  // Gain release rate code.
    logic [3:0] attack;           // Gain attack rate code.
  } lct_timing_t;

  // Configuration register contents.
  typedef struct packed {
    logic [3:0] rateSel;  // Sample rate selector.
    logic       active;   // Set means active, clear means monitor only.
    logic       right;    // Right channel level control enable.
    logic       left;     // Left channel level control enable.
  } lct_cfg_t;

endpackage : lct_pkg

// ==== design/lct_step_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

// Counts weighted sample ticks and reports when a step interval is due.
module lct_step_timer
  import lct_pkg::*;
#(
  parameter int CNT_W = 20
) (
  // Clock and control.
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             clkEn,
  // Timing inputs.
  input  wire logic             run,
  input  wire logic             clear,
  input  wire logic             sampleTick,
  input  wire logic [3:0]       weight,
  input  wire logic [CNT_W-1:0] limit,
  // Interval expiry, combinational.
  output logic                  due
);

  // The longest interval needs 18 bits of count.
  if (CNT_W < 18) begin : gChk
    $error("lct_step_timer: CNT_W must be at least 18.");
  end

  logic [CNT_W-1:0] count_r;   // Elapsed time in 96 kHz units.
  logic [CNT_W:0]   sum;       // Elapsed time after this tick.

  assign sum = {1'b0, count_r} + {{(CNT_W-3){1'b0}}, weight};
  // An interval ends on the tick that reaches its limit.
  assign due = run && sampleTick && (sum >= {1'b0, limit});

  // The count restarts when the interval ends, stops or is cleared.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_r <= '0;
    end else if (clkEn) begin
      if (!run || clear || due) begin
        count_r <= '0;
      end else if (sampleTick) begin
        count_r <= sum[CNT_W-1:0];
      end
    end
  end

endmodule : lct_step_timer

`default_nettype wire

// ==== verif/lct_level_timing_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none

// Port-level checks of the level control step timing block.
module lct_level_timing_asserts
  import lct_pkg::*;
#(
  parameter int CNT_W = 20
) (
  // Clock, reset and clock enable.
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        clkEn,
  // Register port.
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [15:0] regRdData,
  // Level inputs and step outputs.
  input wire logic        sampleTick,
  input wire logic        levelAboveTarget,
  input wire logic        holdExpired,
  input wire logic        peakOverLimit,
  input wire logic        gainDownStep,
  input wire logic        gainUpStep,
  input wire logic        limiterActive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // High when the address names one of the three registers.
  wire logic mapped;
  assign mapped = regAddr == LCT_OFS_TIMING || regAddr == LCT_OFS_CFG
                  || regAddr == LCT_OFS_STATUS;

  chk_rd_one_cycle : assert property (
    regRdData != 16'h0000 |-> $past(regRdEn) || !$past(clkEn))
    else $error("read data outside a read cycle");
  chk_timing_rsvd : assert property (
    regRdEn && clkEn && regAddr == LCT_OFS_TIMING |=> regRdData[15:9] == 7'h00)
    else $error("unused timing bits read nonzero");
  chk_unmapped_zero : assert property (
    regRdEn && clkEn && !mapped |=> regRdData == 16'h0000)
    else $error("unmapped read returned data");
  chk_down_on_tick : assert property (
    gainDownStep |-> $past(sampleTick) || !$past(clkEn))
    else $error("down step without sample tick");
  chk_up_yields : assert property (gainUpStep |-> !gainDownStep)
    else $error("up step beside down step");
  chk_down_cause : assert property (
    gainDownStep |-> $past(levelAboveTarget) || $past(peakOverLimit)
                     || !$past(clkEn))
    else $error("down step without cause");
  chk_up_hold : assert property (
    gainUpStep |-> $past(holdExpired) || !$past(clkEn))
    else $error("up step before hold expired");
  chk_limit_peak : assert property (
    limiterActive |-> $past(peakOverLimit) || !$past(clkEn))
    else $error("limiter active without peak");
endmodule : lct_level_timing_asserts

bind lct_level_timing lct_level_timing_asserts #(.CNT_W(CNT_W))
  lct_level_timing_asserts_inst (
  .core_clk(core_clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .sampleTick(sampleTick),
  .levelAboveTarget(levelAboveTarget), .holdExpired(holdExpired),
  .peakOverLimit(peakOverLimit), .gainDownStep(gainDownStep),
  .gainUpStep(gainUpStep), .limiterActive(limiterActive));

`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

// Self-checking bench for the level control step timing block.
module tb_top;
  import lct_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clkEn = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic        sampleTick = 1'b0;
  logic        levelAboveTarget = 1'b0;
  logic        holdExpired = 1'b0;
  logic        peakOverLimit = 1'b0;
  logic        gainDownStep;
  logic        gainUpStep;
  logic        limiterActive;
  logic        laSeen;       // Limiter flag seen at the last tick.
  logic [15:0] rv;           // Last read value.
  logic [3:0]  rt;           // Random rate code.
  logic [3:0]  cd;           // Random rate field code.
  logic        st;           // Random style.
  logic        up;           // Random ramp direction.
  logic        pk;           // Random peak flag.
  int          miscompares = 0;
  int          cmpCount = 0;
  int          cycles = 0;
  int          seed = 8;
  int          n;
  int          e;
  // Sample weights in 96 kHz units, indexed by rate code.
  int          wTab [16] = '{12, 8, 8, 6, 4, 4, 3, 2, 2, 1, 1, 2, 2, 2, 2, 2};

  lct_level_timing #(.CNT_W(20)) lct_level_timing_inst (
    .core_clk(core_clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .sampleTick(sampleTick),
    .levelAboveTarget(levelAboveTarget), .holdExpired(holdExpired),
    .peakOverLimit(peakOverLimit), .gainDownStep(gainDownStep),
    .gainUpStep(gainUpStep), .limiterActive(limiterActive));

  // Free running 250 MHz clock.
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      miscompares = miscompares + 1;
      finalReport();
    end
  end

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic finalReport();
    $display("compares %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finalReport

  // One register write cycle.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr

  // One register read cycle; data is taken in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  // Channels are switched off before the style changes.
  task automatic setup(input logic s, input logic [3:0] rel,
                       input logic [3:0] atk, input logic [3:0] r,
                       input logic act);
    logic [1:0] en;
    en = 2'({$random(seed)} % 3 + 1);
    wr(LCT_OFS_CFG, {8'h00, r, 4'h0});
    wr(LCT_OFS_TIMING, {7'h00, s, rel, atk});
    wr(LCT_OFS_CFG, {8'h00, r, 1'b0, act, en});
  endtask : setup

  // Runs sample ticks until the watched step shows; n is 0 if none did.
  task automatic stepRun(input logic lat, input logic hd, input logic p,
                         input logic wu, input int lim, output int n);
    logic hit;
    hit = 1'b0;
    n = 0;
    @(posedge core_clk);
    levelAboveTarget <= lat;
    holdExpired <= hd;
    peakOverLimit <= p;
    repeat (2) @(posedge core_clk);
    while (!hit && n < lim) begin
      sampleTick <= 1'b1;
      n++;
      @(posedge core_clk);
      sampleTick <= 1'b0;
      #1 hit = (wu ? gainUpStep : gainDownStep) === 1'b1;
      laSeen = limiterActive;
      @(posedge core_clk);
    end
    if (!hit) n = 0;
    levelAboveTarget <= 1'b0;
    holdExpired <= 1'b0;
    peakOverLimit <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : stepRun

  // Ticks from a cleared timer to the first step.
  function automatic int expTicks(input logic s, input logic [3:0] r,
                                  input logic [3:0] c, input logic u);
    int b;
    logic lim;
    lim = s && r < LCT_RATE_88K;
    if (u) b = lim ? LCT_LIM_REL_U : LCT_NORM_REL_U;
    else b = lim ? LCT_LIM_ATK_U : LCT_NORM_ATK_U;
    return ((b << c) + wTab[r] - 1) / wTab[r];
  endfunction : expTicks

  // Main sequence.
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rd(LCT_OFS_TIMING, rv);
    chk("timing reset", rv, 16'h0032);
    rd(LCT_OFS_CFG, rv);
    chk("cfg reset", rv, 16'h0080);
    rd(LCT_OFS_STATUS, rv);
    chk("status reset", rv, 16'h0000);
    rd(8'h55, rv);
    chk("unmapped read", rv, 16'h0000);
    wr(LCT_OFS_TIMING, 16'hFFFF);
    wr(8'h14, 16'h0000);
    rd(LCT_OFS_TIMING, rv);
    chk("timing write", rv, 16'h01FF);
    // A write while the clock enable is low leaves the register alone.
    clkEn <= 1'b0;
    wr(LCT_OFS_TIMING, 16'h0000);
    clkEn <= 1'b1;
    rd(LCT_OFS_TIMING, rv);
    chk("frozen write", rv, 16'h01FF);
    // Every legal code of both fields in both styles at 8 kHz.
    for (int s = 0; s < 2; s++) begin
      for (int u = 0; u < 2; u++) begin
        for (int c = 0; c <= (u ? 11 : 10); c++) begin
          setup(1'(s), u ? 4'(c) : 4'h0, u ? 4'h0 : 4'(c), LCT_RATE_8K, 1'b1);
          e = expTicks(1'(s), LCT_RATE_8K, 4'(c), 1'(u));
          stepRun(!u, 1'(u), 1'b0, 1'(u), e + 2, n);
          chk("code ticks", 16'(n), 16'(e));
        end
      end
    end
    // Limiter style at 96 kHz falls back to normal times.
    setup(1'b1, 4'h1, 4'h1, LCT_RATE_96K, 1'b1);
    stepRun(1'b1, 1'b0, 1'b0, 1'b0, 40, n);
    chk("high rate", 16'(n), 16'(expTicks(1'b0, LCT_RATE_96K, 4'h1, 1'b0)));
    // Status shows the high rate and no effective limiter style.
    rd(LCT_OFS_STATUS, rv);
    chk("high rate status", rv, 16'h0008);
    // A peak overrides a slow attack code.
    setup(1'b0, 4'h3, 4'hA, LCT_RATE_8K, 1'b1);
    stepRun(1'b0, 1'b0, 1'b1, 1'b0, 10, n);
    chk("peak ticks", 16'(n), 16'h0001);
    chk("peak flag", 16'(laSeen), 16'h0001);
    // Monitor operation ignores the peak.
    setup(1'b1, 4'h3, 4'h5, LCT_RATE_48K, 1'b0);
    stepRun(1'b0, 1'b0, 1'b1, 1'b0, 8, n);
    chk("monitor ticks", 16'(n), 16'h0000);
    chk("monitor flag", 16'(laSeen), 16'h0000);
    // Limiter steps every tick and keeps the release step from landing.
    // At 8 kHz both intervals end on the very first tick.
    setup(1'b1, 4'h0, 4'h5, LCT_RATE_8K, 1'b1);
    stepRun(1'b0, 1'b1, 1'b1, 1'b1, 40, n);
    chk("up yields", 16'(n), 16'h0000);
    // Random rates, styles, directions and peaks.
    repeat (8) begin
      rt = 4'({$random(seed)} % 11);
      st = 1'($random(seed));
      up = 1'($random(seed));
      pk = !up && 1'($random(seed));
      cd = 4'($random(seed)) & 4'h6;
      setup(st, cd, cd, rt, 1'b1);
      e = expTicks(st, rt, pk ? 4'h0 : cd, up);
      stepRun(!up && !pk, up, pk, up, e + 2, n);
      chk("random ticks", 16'(n), 16'(e));
      chk("random flag", 16'(laSeen), 16'(pk));
    end
    finalReport();
  end
endmodule : tb_top

`default_nettype wire
